// file: logic/psc_pkg.sv
package psc_pkg;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_CLK_DIV    = 3'h0;
  localparam logic [2:0] ADDR_MOD_DIS_1  = 3'h1;
  localparam logic [2:0] ADDR_MOD_DIS_2  = 3'h2;
  localparam logic [2:0] ADDR_MOD_DIS_3  = 3'h3;
  localparam logic [2:0] ADDR_STATUS     = 3'h4;

  // clock divider register fields
  localparam int CLK_DIV_ROI_BIT    = 15;
  localparam int CLK_DIV_RATIO_HI   = 14;
  localparam int CLK_DIV_RATIO_LO   = 12;
  localparam int CLK_DIV_CPU_SLOW_ENABLE_BIT  = 11;
  localparam logic [15:0] CLK_DIV_MASK  = 16'hF800;
  localparam logic [15:0] CLK_DIV_RESET = 16'h0000;

  // implemented bits of the module disable registers
  localparam logic [15:0] MOD_DIS_1_MASK = 16'hF8FB;
  localparam logic [15:0] MOD_DIS_2_MASK = 16'hC30F;
  localparam logic [15:0] MOD_DIS_3_MASK = 16'h07C0;
  localparam logic [15:0] MOD_DIS_RESET  = 16'h0000;

  // wake-up delay range in cycles
  localparam logic [1:0] WAKE_MIN_CYC = 2'h2;
  localparam logic [1:0] WAKE_MAX_CYC = 2'h3;

  // power-save operand encodings
  localparam logic [1:0] PSAVE_NONE  = 2'h0;
  localparam logic [1:0] PSAVE_SLEEP = 2'h1;
  localparam logic [1:0] PSAVE_IDLE  = 2'h2;

  localparam int NUM_GATES = 48;

  typedef enum logic [3:0] {
    PSC_RUN   = 4'h1,
    PSC_SLEEP = 4'h2,
    PSC_IDLE  = 4'h4,
    PSC_WAKE  = 4'h8
  } psc_state_t;

  // core request group
  typedef struct packed {
    logic       psave_valid;
    logic [1:0] psave_mode;
    logic       irq_pending;
    logic       wdt_timeout;
    logic       wdt_enable;
    logic       fail_safe_clock_monitor_enable;
  } psc_core_in_t;

  // register port request group
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } psc_bus_t;

  // gating outputs
  typedef struct packed {
    logic                 cpu_clk_en;
    logic                 sys_clk_en;
    logic                 periph_clk_en;
    logic                 osc_run;
    logic                 low_power_rc_clock_run;
    logic                 fail_safe_clock_monitor_active;
    logic                 wdt_clear;
    logic                 cpu_resume;
    logic [NUM_GATES-1:0] module_enable;
  } psc_gate_t;

endpackage : psc_pkg

// file: logic/psc_power_ctrl.sv
`timescale 1ns/1ns
module psc_power_ctrl
  import psc_pkg::*;
#(
  parameter logic [NUM_GATES-1:0] PRESENT = {NUM_GATES{1'b1}}
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // core and watchdog signals
  input  wire psc_core_in_t core_in,
  // register port
  input  wire psc_bus_t     bus,
  output logic [15:0]       rdata,
  // clock gating outputs
  output psc_gate_t         gate
);

  // whole module state
  typedef struct packed {
    psc_state_t           st;
    logic [1:0]           wcnt;
    logic [15:0]          clock_divider_reg;
    logic [15:0]          dis1;
    logic [15:0]          dis2;
    logic [15:0]          dis3;
    logic [6:0]           doze_cnt;
    logic                 held_irq;
    logic [15:0]          rdata;
    psc_gate_t            gate;
  } psc_regs_t;

  psc_regs_t s_q;
  psc_regs_t s_d;

  logic                 doze_on;
  logic [6:0]           doze_top;
  logic                 doze_tick;
  logic                 wake;
  logic [NUM_GATES-1:0] dis_all;
  logic [15:0]          status;

  // doze divider terminal count from the ratio field
  always_comb
  begin
    doze_on   = s_q.clock_divider_reg[CLK_DIV_CPU_SLOW_ENABLE_BIT];
    doze_top  = 7'((8'h01 << s_q.clock_divider_reg[CLK_DIV_RATIO_HI:CLK_DIV_RATIO_LO]) - 8'h01);
    doze_tick = !doze_on || (s_q.doze_cnt == doze_top);
    wake      = core_in.irq_pending || core_in.wdt_timeout || s_q.held_irq;
    dis_all   = {s_q.dis3, s_q.dis2, s_q.dis1};
    status    = {12'h000, s_q.st};
  end

  // next state, registers and gating
  always_comb
  begin
    s_d = s_q;
    s_d.gate.wdt_clear  = 1'b0;
    s_d.gate.cpu_resume = 1'b0;
    s_d.doze_cnt = doze_tick ? 7'h00 : 7'(s_q.doze_cnt + 7'h01);
    // register writes
    if (bus.wr)
    begin
      case (bus.addr)
        ADDR_CLK_DIV:   s_d.clock_divider_reg = bus.wdata & CLK_DIV_MASK;
        ADDR_MOD_DIS_1: s_d.dis1   = bus.wdata & MOD_DIS_1_MASK;
        ADDR_MOD_DIS_2: s_d.dis2   = bus.wdata & MOD_DIS_2_MASK;
        ADDR_MOD_DIS_3: s_d.dis3   = bus.wdata & MOD_DIS_3_MASK;
        default: ;
      endcase
    end
    // recovery from doze on interrupt; hardware wins over a write
    if (core_in.irq_pending && s_q.clock_divider_reg[CLK_DIV_ROI_BIT])
    begin
      s_d.clock_divider_reg[CLK_DIV_CPU_SLOW_ENABLE_BIT] = 1'b0;
      s_d.doze_cnt = 7'h00;
    end
    // register reads, data one cycle later
    s_d.rdata = 16'h0000;
    if (bus.rd)
    begin
      case (bus.addr)
        ADDR_CLK_DIV:   s_d.rdata = s_q.clock_divider_reg;
        ADDR_MOD_DIS_1: s_d.rdata = s_q.dis1;
        ADDR_MOD_DIS_2: s_d.rdata = s_q.dis2;
        ADDR_MOD_DIS_3: s_d.rdata = s_q.dis3;
        ADDR_STATUS:    s_d.rdata = status;
        default:        s_d.rdata = 16'h0000;
      endcase
    end
    // power state machine
    case (s_q.st)
      PSC_RUN:
      begin
        if (core_in.psave_valid && core_in.psave_mode == PSAVE_SLEEP)
        begin
          s_d.st = PSC_SLEEP;
          s_d.gate.wdt_clear = core_in.wdt_enable;
          s_d.held_irq = core_in.irq_pending;
        end
        else if (core_in.psave_valid && core_in.psave_mode == PSAVE_IDLE)
        begin
          s_d.st = PSC_IDLE;
          s_d.gate.wdt_clear = 1'b1;
          s_d.held_irq = core_in.irq_pending;
        end
      end
      PSC_SLEEP, PSC_IDLE:
      begin
        s_d.held_irq = 1'b0;
        if (wake)
        begin
          s_d.st   = PSC_WAKE;
          s_d.wcnt = 2'h0;
        end
      end
      PSC_WAKE:
      begin
        s_d.wcnt = 2'(s_q.wcnt + 2'h1);
        if (s_q.wcnt + 2'h1 >= WAKE_MIN_CYC)
        begin
          s_d.st = PSC_RUN;
          s_d.gate.cpu_resume = 1'b1;
        end
      end
      default: s_d.st = PSC_RUN;
    endcase
    // clock gating from the next state
    s_d.gate.sys_clk_en    = (s_d.st != PSC_SLEEP);
    s_d.gate.osc_run       = (s_d.st != PSC_SLEEP);
    s_d.gate.periph_clk_en = (s_d.st != PSC_SLEEP);
    s_d.gate.fail_safe_clock_monitor_active   = (s_d.st != PSC_SLEEP) && core_in.fail_safe_clock_monitor_enable;
    s_d.gate.low_power_rc_clock_run      = core_in.wdt_enable ||
                             ((s_d.st != PSC_SLEEP) && core_in.fail_safe_clock_monitor_enable);
    s_d.gate.cpu_clk_en    = (s_d.st == PSC_RUN) && doze_tick;
    // module enables follow the disable bits one cycle later
    s_d.gate.module_enable = PRESENT & ~dis_all &
                             {NUM_GATES{s_d.st != PSC_SLEEP}};
  end

  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '{st: PSC_RUN, wcnt: 2'h0, clock_divider_reg: CLK_DIV_RESET, dis1: MOD_DIS_RESET,
               dis2: MOD_DIS_RESET, dis3: MOD_DIS_RESET, doze_cnt: 7'h00, held_irq: 1'b0,
               rdata: 16'h0000,
               gate: '{cpu_clk_en: 1'b1, sys_clk_en: 1'b1, periph_clk_en: 1'b1,
                       osc_run: 1'b1, low_power_rc_clock_run: 1'b1, fail_safe_clock_monitor_active: 1'b0, wdt_clear: 1'b0,
                       cpu_resume: 1'b0, module_enable: {NUM_GATES{1'b1}}}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign rdata = s_q.rdata;
  assign gate  = s_q.gate;

endmodule : psc_power_ctrl

// file: tb/psc_checker_properties.sv
`timescale 1ns/1ns
module psc_checker
  import psc_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         reset_n,
  // watched ports
  input wire psc_core_in_t core_in,
  input wire psc_bus_t     bus,
  input wire logic [15:0]  rdata,
  input wire psc_gate_t    gate
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // decoded power-save requests
  logic sl;
  logic id;
  assign sl = core_in.psave_valid && core_in.psave_mode == PSAVE_SLEEP;
  assign id = core_in.psave_valid && core_in.psave_mode == PSAVE_IDLE;

  idle_entry_a:
    assert property (id |=> !gate.cpu_clk_en && gate.wdt_clear) else $error("idle entry wrong");
  idle_clocks_a:
    assert property (id && core_in.fail_safe_clock_monitor_enable |=> gate.sys_clk_en && gate.periph_clk_en && gate.low_power_rc_clock_run)
      else $error("idle clocks wrong");
  sleep_stop_a:
    assert property (sl |=> !gate.sys_clk_en && !gate.osc_run && !gate.fail_safe_clock_monitor_active && gate.module_enable == '0)
      else $error("sleep clocks still on");
  low_power_rc_clock_sleep_a:
    assert property (sl && core_in.wdt_enable |=> gate.low_power_rc_clock_run) else $error("rc clock off in sleep");
  wake_resume_a:
    assert property (gate.wdt_clear && core_in.irq_pending |-> ##[2:4] gate.cpu_resume) else $error("wake late");
  irq_held_a:
    assert property (core_in.psave_valid && core_in.irq_pending |-> ##[3:5] gate.cpu_resume)
      else $error("held interrupt lost");
  read_unmapped_a:
    assert property (bus.rd && bus.addr > ADDR_STATUS |=> rdata == 16'h0000) else $error("unmapped read not zero");
  disable_delay_a:
    assert property (bus.wr && bus.addr == ADDR_MOD_DIS_1 |-> ##2
      (gate.module_enable[15:0] & MOD_DIS_1_MASK) == (~$past(bus.wdata, 2) & MOD_DIS_1_MASK))
      else $error("module gate delay wrong");
endmodule : psc_checker

// file: tb/test_power_save_clock_gating.sv
`timescale 1ns/1ns
module test_power_save_clock_gating;
  import psc_pkg::*;
  logic         clk = 0;
  logic         reset_n = 0;
  psc_core_in_t ci = '0;
  psc_bus_t     bs = '0;
  logic [15:0]  rdata;
  psc_gate_t    gate;
  int           failures = 0;
  int           check_count = 0;
  int           n;
  logic [47:0]  mk;
  // device under test
  psc_power_ctrl DUT (.clk(clk), .reset_n(reset_n), .core_in(ci), .bus(bs), .rdata(rdata), .gate(gate));
  always #25 clk = ~clk;
  task automatic chk(logic [47:0] s, logic [47:0] e);
    check_count++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(logic [2:0] a, logic [15:0] d);
    @(posedge clk);
    bs <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bs.wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [2:0] a, logic [15:0] e);
    @(posedge clk);
    bs <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bs.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  task automatic psave(logic [1:0] m);
    @(posedge clk);
    ci.psave_valid <= 1'b1;
    ci.psave_mode <= m;
    @(posedge clk);
    ci.psave_valid <= 1'b0;
    #1;
  endtask : psave
  task automatic resume();
    for (n = 0; n < 8 && gate.cpu_resume !== 1'b1; n++) cyc(1);
    chk(gate.cpu_resume, 1'b1);
    cyc(1);
    chk(gate.cpu_clk_en, 1'b1);
  endtask : resume
  task automatic count();
    n = 0;
    repeat (256)
    begin
      cyc(1);
      n += gate.cpu_clk_en;
    end
  endtask : count
  // register layout and module gating
  task automatic t_regs();
    mk = {MOD_DIS_3_MASK, MOD_DIS_2_MASK, MOD_DIS_1_MASK};
    chk(gate.module_enable, '1);
    rd(3'h5, 16'h0000);
    rd(ADDR_STATUS, 16'(PSC_RUN));
    for (int a = 1; a < 4; a++) wr(a[2:0], 16'hFFFF);
    wr(3'h6, 16'hFFFF);
    rd(ADDR_MOD_DIS_1, 16'hF8FB);
    rd(ADDR_MOD_DIS_2, 16'hC30F);
    rd(ADDR_MOD_DIS_3, 16'h07C0);
    chk(gate.module_enable & mk, '0);
    for (int a = 1; a < 4; a++) wr(a[2:0], 16'h0000);
    cyc(2);
    chk(gate.module_enable & mk, mk);
  endtask : t_regs
  // idle with one module off, then a coincident interrupt
  task automatic t_idle();
    wr(ADDR_MOD_DIS_1, 16'h0001);
    ci.fail_safe_clock_monitor_enable <= 1'b1;
    psave(PSAVE_IDLE);
    chk({gate.cpu_clk_en, gate.sys_clk_en, gate.periph_clk_en, gate.low_power_rc_clock_run, gate.wdt_clear}, 5'h0F);
    chk(gate.module_enable[0], 1'b0);
    rd(ADDR_STATUS, 16'(PSC_IDLE));
    cyc(5);
    chk(gate.cpu_clk_en, 1'b0);
    ci.irq_pending <= 1'b1;
    resume();
    psave(PSAVE_IDLE);
    chk(gate.cpu_clk_en, 1'b0);
    resume();
    ci.irq_pending <= 1'b0;
  endtask : t_idle
  // sleep with watchdog on, woken by time-out
  task automatic t_sleep();
    ci.wdt_enable <= 1'b1;
    psave(PSAVE_SLEEP);
    chk({gate.sys_clk_en, gate.osc_run, gate.fail_safe_clock_monitor_active, gate.low_power_rc_clock_run, gate.wdt_clear}, 5'h03);
    chk(gate.module_enable, '0);
    cyc(4);
    ci.wdt_timeout <= 1'b1;
    resume();
    ci.wdt_timeout <= 1'b0;
    chk({gate.sys_clk_en, gate.osc_run}, 2'h3);
  endtask : t_sleep
  // every doze ratio, then recovery with and without the recover bit
  task automatic t_doze();
    for (int r = 0; r < 8; r++)
    begin
      wr(ADDR_CLK_DIV, 16'h0800 | 16'(r << 12));
      cyc(2);
      count();
      chk(n, 256 >> r);
    end
    wr(ADDR_CLK_DIV, 16'h3800);
    ci.irq_pending <= 1'b1;
    cyc(2);
    ci.irq_pending <= 1'b0;
    rd(ADDR_CLK_DIV, 16'h3800);
    wr(ADDR_CLK_DIV, 16'hA800);
    ci.irq_pending <= 1'b1;
    cyc(2);
    ci.irq_pending <= 1'b0;
    rd(ADDR_CLK_DIV, 16'hA000);
    count();
    chk(n, 256);
  endtask : t_doze
  task automatic give_verdict();
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    cyc(1);
    t_regs();
    t_idle();
    t_sleep();
    t_doze();
    give_verdict();
  end
  // watchdog against a hang
  initial
  begin
    #300000;
    failures++;
    give_verdict();
  end
endmodule : test_power_save_clock_gating
bind psc_power_ctrl psc_checker u_chk (.clk(clk), .reset_n(reset_n), .core_in(core_in), .bus(bus), .rdata(rdata),
  .gate(gate));
